// ===== design/acr_pkg.sv
package acr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_RATE_CFG  = 8'h01;
    localparam logic [7:0] ADDR_READY_CFG = 8'h02;
    localparam logic [7:0] ADDR_ROUTE_CFG = 8'h03;

    // Every register comes out of reset at zero
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field codes
    localparam logic [2:0] RATE_RESERVED  = 3'h7;
    localparam logic [2:0] ROUTE_OFF      = 3'h0;
    localparam logic [2:0] ROUTE_RESERVED = 3'h7;
    localparam logic [1:0] REF_INTERNAL   = 2'h0;
    localparam logic [1:0] REF_EXTERNAL   = 2'h1;
    localparam logic [1:0] INTEG_INVERT   = 2'h1;
    localparam logic [1:0] INTEG_CRC      = 2'h2;

    // Modulator clock in kHz
    localparam logic [9:0] MOD_KHZ_NORMAL = 10'h100;
    localparam logic [9:0] MOD_KHZ_TURBO  = 10'h200;

    typedef struct packed {
        logic [2:0] rate_select;
        logic       turbo_mode;
        logic       conv_continuous;
        logic [1:0] ref_select;
        logic       temp_sense_enable;
    } acr_rate_cfg_s;

    typedef struct packed {
        logic       result_ready_flag;
        logic       frame_counter_enable;
        logic [1:0] integrity_select;
        logic       burnout_source_enable;
        logic [2:0] excitation_current_level;
    } acr_ready_cfg_s;

    typedef struct packed {
        logic [2:0] exc_one_route;
        logic [2:0] exc_two_route;
        logic       reserved_zero;
        logic       auto_output;
    } acr_route_cfg_s;

    // One register access from the serial command decoder
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acr_req_s;

    // Decoded controls for the converter core
    typedef struct packed {
        logic [10:0] sps;
        logic        rate_valid;
        logic [9:0]  mod_khz;
        logic        conv_continuous;
        logic [1:0]  ref_effective;
        logic        temp_sense_enable;
        logic        ignore_mux_cfg;
        logic        frame_counter_enable;
        logic        append_inverted;
        logic        append_crc;
        logic        burnout_source_enable;
        logic [10:0] excitation_ua;
        logic [5:0]  exc_one_sel;
        logic [5:0]  exc_two_sel;
        logic        auto_output;
        logic        result_ready_flag;
    } acr_ctrl_s;

    typedef struct packed {
        acr_rate_cfg_s  cfg1;
        acr_ready_cfg_s cfg2;
        acr_route_cfg_s cfg3;
        logic [7:0]     rdata;
        logic           rd_valid;
        logic           rd_hit;
    } acr_state_s;

    // Samples per second; turbo doubles every entry
    function automatic logic [10:0] acr_sps(input logic [2:0] code, input logic turbo);
        logic [10:0] base;
        base = 11'h000;
        case (code)
            3'h0: base = 11'h014;
            3'h1: base = 11'h02D;
            3'h2: base = 11'h05A;
            3'h3: base = 11'h0AF;
            3'h4: base = 11'h14A;
            3'h5: base = 11'h258;
            3'h6: base = 11'h3E8;
            default: base = 11'h000;
        endcase
        return turbo ? {base[9:0], 1'b0} : base;
    endfunction : acr_sps

    // Excitation current in microamps
    function automatic logic [10:0] acr_ua(input logic [2:0] code);
        logic [10:0] ua;
        ua = 11'h000;
        case (code)
            3'h1: ua = 11'h00A;
            3'h2: ua = 11'h032;
            3'h3: ua = 11'h064;
            3'h4: ua = 11'h0FA;
            3'h5: ua = 11'h1F4;
            3'h6: ua = 11'h3E8;
            3'h7: ua = 11'h5DC;
            default: ua = 11'h000;
        endcase
        return ua;
    endfunction : acr_ua

    // One-hot: bits 0..3 analog inputs, 4 ref pos, 5 ref neg
    function automatic logic [5:0] acr_route(input logic [2:0] code);
        logic [5:0] sel;
        sel = 6'h00;
        if (code != ROUTE_OFF && code != ROUTE_RESERVED) begin
            sel[3'(code - 3'h1)] = 1'b1;
        end
        return sel;
    endfunction : acr_route

endpackage : acr_pkg

// ===== design/acr_config_bank.sv
module acr_config_bank (
    input  wire logic              CLK,
    input  wire logic              RESETN,
    input  wire acr_pkg::acr_req_s HOST_REQ,
    input  wire logic              RESULT_NEW,
    input  wire logic              DATA_READ,
    output logic [7:0]             RD_DATA,
    output logic                   RD_VALID,
    output logic                   RD_HIT,
    output acr_pkg::acr_ctrl_s     CTRL
);

    logic               rst_meta_r;
    logic               rst_n;
    acr_pkg::acr_state_s st_r;
    acr_pkg::acr_state_s st_nxt;
    logic               hit1;
    logic               hit2;
    logic               hit3;

    // Reset enters asynchronously, but release is synchronised
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // Address decode
    always_comb begin
        hit1 = 1'b0;
        hit2 = 1'b0;
        hit3 = 1'b0;
        if (HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG) begin
            hit1 = 1'b1;
        end else if (HOST_REQ.addr == acr_pkg::ADDR_READY_CFG) begin
            hit2 = 1'b1;
        end else if (HOST_REQ.addr == acr_pkg::ADDR_ROUTE_CFG) begin
            hit3 = 1'b1;
        end
    end

    // Next state: writes, ready flag and read answer
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rd_valid = HOST_REQ.rd_en;
        st_nxt.rd_hit   = HOST_REQ.rd_en & (hit1 | hit2 | hit3);
        st_nxt.rdata    = st_r.rdata;

        // Reads return the value before any write in the same cycle
        if (HOST_REQ.rd_en) begin
            if (hit1) begin
                st_nxt.rdata = st_r.cfg1;
            end else if (hit2) begin
                st_nxt.rdata = st_r.cfg2;
            end else if (hit3) begin
                st_nxt.rdata = st_r.cfg3;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end

        // Reserved codes are stored as written; decode treats them as off
        if (HOST_REQ.wr_en && hit1) begin
            st_nxt.cfg1 = HOST_REQ.wdata;
        end
        if (HOST_REQ.wr_en && hit2) begin
            st_nxt.cfg2                   = HOST_REQ.wdata;
            st_nxt.cfg2.result_ready_flag = st_r.cfg2.result_ready_flag;
        end
        if (HOST_REQ.wr_en && hit3) begin
            st_nxt.cfg3               = HOST_REQ.wdata;
            st_nxt.cfg3.reserved_zero = 1'b0;
        end

        // A new result in the same cycle as a data read wins
        st_nxt.cfg2.result_ready_flag = RESULT_NEW |
            (st_r.cfg2.result_ready_flag & ~DATA_READ);
    end

    // All registers clear to zero
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA  = st_r.rdata;
    assign RD_VALID = st_r.rd_valid;
    assign RD_HIT   = st_r.rd_hit;

    // One process fills the whole control word, so it has a single driver
    always_comb begin
        // Rate and modulator clock
        CTRL.sps             = acr_pkg::acr_sps(st_r.cfg1.rate_select, st_r.cfg1.turbo_mode);
        CTRL.rate_valid      = st_r.cfg1.rate_select != acr_pkg::RATE_RESERVED;
        CTRL.mod_khz         = st_r.cfg1.turbo_mode ? acr_pkg::MOD_KHZ_TURBO : acr_pkg::MOD_KHZ_NORMAL;
        CTRL.conv_continuous = st_r.cfg1.conv_continuous;
        // Temperature sensing overrides the reference choice
        CTRL.ref_effective     = st_r.cfg1.temp_sense_enable ? acr_pkg::REF_INTERNAL
                                                             : st_r.cfg1.ref_select;
        CTRL.temp_sense_enable = st_r.cfg1.temp_sense_enable;
        CTRL.ignore_mux_cfg    = st_r.cfg1.temp_sense_enable;
        // Output framing and sensor checks
        CTRL.frame_counter_enable  = st_r.cfg2.frame_counter_enable;
        CTRL.append_inverted       = st_r.cfg2.integrity_select == acr_pkg::INTEG_INVERT;
        CTRL.append_crc            = st_r.cfg2.integrity_select == acr_pkg::INTEG_CRC;
        CTRL.burnout_source_enable = st_r.cfg2.burnout_source_enable;
        CTRL.result_ready_flag     = st_r.cfg2.result_ready_flag;
        // Excitation magnitude and routing
        CTRL.excitation_ua = acr_pkg::acr_ua(st_r.cfg2.excitation_current_level);
        CTRL.exc_one_sel   = acr_pkg::acr_route(st_r.cfg3.exc_one_route);
        CTRL.exc_two_sel   = acr_pkg::acr_route(st_r.cfg3.exc_two_route);
        CTRL.auto_output   = st_r.cfg3.auto_output;
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_n);

    // Normal rate after a write
    rate_normal_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        && HOST_REQ.wdata[7:4] == 4'hA
        |=> CTRL.sps == 11'h258 && CTRL.rate_valid)
        else $error("normal rate code 5 not 600 SPS");

    // Turbo rate after a write
    rate_turbo_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        && HOST_REQ.wdata[7:4] == 4'hD
        |=> CTRL.sps == 11'h7D0)
        else $error("turbo rate code 6 not 2000 SPS");

    // Modulator clock follows the mode bit
    mod_clock_a : assert property (
        CTRL.mod_khz == (st_r.cfg1.turbo_mode ? 10'h200 : 10'h100))
        else $error("modulator clock does not match mode");

    // Conversion style stored from the write
    conv_style_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        |=> CTRL.conv_continuous == $past(HOST_REQ.wdata[3]))
        else $error("conversion style not stored");

    // External reference passes through when sensing is off
    ref_pass_a : assert property (
        !st_r.cfg1.temp_sense_enable
        |-> CTRL.ref_effective == st_r.cfg1.ref_select)
        else $error("reference choice not passed through");

    // Temperature sensing forces internal reference
    temp_force_a : assert property (
        st_r.cfg1.temp_sense_enable
        |-> CTRL.ref_effective == 2'h0 && CTRL.ignore_mux_cfg)
        else $error("temperature mode did not force internal reference");

    // A new result always raises the flag
    ready_set_a : assert property (
        RESULT_NEW |=> CTRL.result_ready_flag)
        else $error("ready flag missed a result");

    // A data read without a new result clears it
    ready_clear_a : assert property (
        DATA_READ && !RESULT_NEW |=> !CTRL.result_ready_flag)
        else $error("ready flag not cleared by data read");

    // Inverted-copy code selects only that check
    integ_excl_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        && HOST_REQ.wdata[5:4] == 2'h1
        |=> CTRL.append_inverted && !CTRL.append_crc)
        else $error("inverted copy code not decoded");

    // Largest current code
    exc_level_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        && HOST_REQ.wdata[2:0] == 3'h7
        |=> CTRL.excitation_ua == 11'h5DC)
        else $error("current code 7 not 1500 uA");

    // Source one to ref pos
    route_one_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_ROUTE_CFG
        && HOST_REQ.wdata[7:5] == 3'h5
        |=> CTRL.exc_one_sel == 6'h10)
        else $error("source one not routed to ref pos");

    // Source two reserved code routes nowhere
    route_two_a : assert property (
        st_r.cfg3.exc_two_route == 3'h7 |-> CTRL.exc_two_sel == 6'h00)
        else $error("reserved route code drives a pin");

    // Reserved bit reads zero
    rsv_zero_a : assert property (
        HOST_REQ.rd_en && HOST_REQ.addr == acr_pkg::ADDR_ROUTE_CFG
        |=> RD_VALID && RD_HIT && RD_DATA[1] == 1'b0)
        else $error("reserved bit read as one");

    // Write keeps the ready flag
    ro_keep_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        && !RESULT_NEW && !DATA_READ
        |=> $stable(CTRL.result_ready_flag))
        else $error("write changed the ready flag");

    // Read-back of a written value
    readback_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        ##1 HOST_REQ.rd_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        && !HOST_REQ.wr_en
        |=> RD_DATA == $past(HOST_REQ.wdata, 2))
        else $error("read-back differs from write");

    // Auto output stored from the write
    auto_out_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_ROUTE_CFG
        |=> CTRL.auto_output == $past(HOST_REQ.wdata[0]))
        else $error("auto output bit not stored");

    // Reserved rate code gives no valid rate
    rate_rsvd_a : assert property (
        st_r.cfg1.rate_select == 3'h7 |-> !CTRL.rate_valid && CTRL.sps == 11'h000)
        else $error("reserved rate code treated as valid");

    // Slowest turbo rate after a write
    rate_slow_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        && HOST_REQ.wdata[7:4] == 4'h1
        |=> CTRL.sps == 11'h028)
        else $error("turbo rate code 0 not 40 SPS");

    // External reference applies while sensing is off
    ref_ext_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_RATE_CFG
        && HOST_REQ.wdata[2:0] == 3'h2
        |=> CTRL.ref_effective == 2'h1)
        else $error("external reference code not applied");

    // Frame counter enable stored from the write
    frame_cnt_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        |=> CTRL.frame_counter_enable == $past(HOST_REQ.wdata[6]))
        else $error("frame counter enable not stored");

    // Checksum code selects only the checksum
    integ_crc_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        && HOST_REQ.wdata[5:4] == 2'h2
        |=> CTRL.append_crc && !CTRL.append_inverted)
        else $error("checksum code not decoded");

    // Burn-out sources follow the written bit
    burnout_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        |=> CTRL.burnout_source_enable == $past(HOST_REQ.wdata[3]))
        else $error("burn-out source bit not stored");

    // Current code zero turns both sources off
    exc_off_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_READY_CFG
        && HOST_REQ.wdata[2:0] == 3'h0
        |=> CTRL.excitation_ua == 11'h000)
        else $error("current code 0 not off");

    // Source two to ref neg
    route_neg_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_ROUTE_CFG
        && HOST_REQ.wdata[4:2] == 3'h6
        |=> CTRL.exc_two_sel == 6'h20)
        else $error("source two not routed to ref neg");

    // Reserved bit never stores a one
    rsv_store_a : assert property (
        HOST_REQ.wr_en && HOST_REQ.addr == acr_pkg::ADDR_ROUTE_CFG |=> !st_r.cfg3.reserved_zero)
        else $error("reserved bit stored a one");

    // Unmapped reads answer zero with no hit
    unmapped_a : assert property (
        HOST_REQ.rd_en && !(HOST_REQ.addr inside {8'h01, 8'h02, 8'h03})
        |=> RD_VALID && !RD_HIT && RD_DATA == 8'h00)
        else $error("unmapped read gave data or a hit");

    // Flag holds without an event, so host writes cannot move it
    ready_held_a : assert property (
        !RESULT_NEW && !DATA_READ |=> $stable(CTRL.result_ready_flag))
        else $error("ready flag moved without an event");

endmodule : acr_config_bank

// ===== tb/acr_host_model.sv
module acr_host_model (
    input  wire logic         clk,
    output acr_pkg::acr_req_s host_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // Expected {hit, data} of each read in flight, oldest first
    logic [8:0] exp_q [$];

    initial host_req = '0;

    // One write cycle; the reserved routing bit goes out as zero unless a fault is wanted
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic brk);
        @(posedge clk);
        if (a == acr_pkg::ADDR_ROUTE_CFG && !brk) d[1] = 1'h0;
        host_req <= '{wr_en: 1'h1, rd_en: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        host_req <= '0;
    endtask : wr

    // One read cycle; the answer is noted before the request leaves
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        host_req <= '{wr_en: 1'h0, rd_en: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        host_req <= '0;
    endtask : rd

    // Write, then read the same address in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        @(posedge clk);
        host_req <= '{wr_en: 1'h1, rd_en: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        exp_q.push_back(e);
        host_req <= '{wr_en: 1'h0, rd_en: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        host_req <= '0;
    endtask : wr_rd
endmodule : acr_host_model

// ===== tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk;
    logic               rst_n;
    logic               result_new;
    logic               data_read;
    acr_pkg::acr_req_s  host_req;
    logic [7:0]         rd_data;
    logic               rd_valid;
    logic               rd_hit;
    acr_pkg::acr_ctrl_s ctrl;
    logic [7:0]         shadow [1:3];
    int                 n_mismatch;
    int                 samples_checked;
    int                 seed;
    logic [7:0]         ra;

    acr_config_bank dut (
        .CLK        (clk),
        .RESETN     (rst_n),
        .HOST_REQ   (host_req),
        .RESULT_NEW (result_new),
        .DATA_READ  (data_read),
        .RD_DATA    (rd_data),
        .RD_VALID   (rd_valid),
        .RD_HIT     (rd_hit),
        .CTRL       (ctrl)
    );

    acr_host_model host (
        .clk      (clk),
        .host_req (host_req)
    );

    // 125 MHz clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [5:0] route(input logic [2:0] k);
        return (k == 3'h0 || k == 3'h7) ? 6'h00 : 6'h01 << (k - 3'h1);
    endfunction : route

    // Controls expected from the shadow copy; turbo doubles the normal rate
    function automatic acr_pkg::acr_ctrl_s decode();
        logic [10:0]        rates [8];
        logic [10:0]        amps [8];
        acr_pkg::acr_ctrl_s c;
        rates = '{11'h014, 11'h02D, 11'h05A, 11'h0AF, 11'h14A, 11'h258, 11'h3E8, 11'h000};
        amps = '{11'h000, 11'h00A, 11'h032, 11'h064, 11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC};
        c.sps = shadow[1][4] ? rates[shadow[1][7:5]] << 1 : rates[shadow[1][7:5]];
        c.rate_valid = shadow[1][7:5] != 3'h7;
        c.mod_khz = shadow[1][4] ? 10'h200 : 10'h100;
        c.conv_continuous = shadow[1][3];
        c.ref_effective = shadow[1][0] ? 2'h0 : shadow[1][2:1];
        c.temp_sense_enable = shadow[1][0];
        c.ignore_mux_cfg = shadow[1][0];
        c.frame_counter_enable = shadow[2][6];
        c.append_inverted = shadow[2][5:4] == 2'h1;
        c.append_crc = shadow[2][5:4] == 2'h2;
        c.burnout_source_enable = shadow[2][3];
        c.excitation_ua = amps[shadow[2][2:0]];
        c.exc_one_sel = route(shadow[3][7:5]);
        c.exc_two_sel = route(shadow[3][4:2]);
        c.auto_output = shadow[3][0];
        c.result_ready_flag = shadow[2][7];
        return c;
    endfunction : decode

    // Writes update the shadow only where the bits are writable, then the decode is compared
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic brk);
        host.wr(a, d, brk);
        if (a == 8'h01) shadow[1] = d;
        if (a == 8'h02) shadow[2] = {shadow[2][7], d[6:0]};
        if (a == 8'h03) shadow[3] = {d[7:2], 1'h0, d[0]};
        #1;
        check(ctrl, decode());
    endtask : wr_reg

    task automatic rd_exp(input logic [7:0] a);
        host.rd(a, (a inside {8'h01, 8'h02, 8'h03}) ? {1'h1, shadow[a[1:0]]} : 9'h000);
    endtask : rd_exp

    // Result and read-out events; a set in the same cycle as a clear wins
    task automatic pulse(input logic nw, input logic dr);
        @(posedge clk);
        result_new <= nw;
        data_read <= dr;
        @(posedge clk);
        result_new <= 1'h0;
        data_read <= 1'h0;
        shadow[2][7] = nw ? 1'h1 : (dr ? 1'h0 : shadow[2][7]);
        #1;
        check(ctrl, decode());
    endtask : pulse

    // Each read answer is matched against the oldest noted expectation
    always @(posedge clk) begin
        if (rd_valid === 1'h1)
            check({rd_hit, rd_data}, host.exp_q.size() != 0 ? host.exp_q.pop_front() : 64'hx);
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        check(64'h1, 64'h0);
        conclude();
    end

    initial begin
        seed = 32'h7e3c_abe5;
        rst_n = 1'h0;
        result_new = 1'h0;
        data_read = 1'h0;
        shadow = '{8'h00, 8'h00, 8'h00};
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        check(ctrl, decode());
        for (int a = 0; a < 5; a++) rd_exp(8'(a));
        rd_exp(8'hFF);
        // Every rate code in both modes, reserved code included
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 8; c++) wr_reg(8'h01, {3'(c), m[0], 4'h0}, 1'h0);
        // Every integrity, current and route code, with the read-only bits pushed high
        for (int k = 0; k < 8; k++) begin
            wr_reg(8'h02, {1'h1, k[0], k[1:0], k[2], 3'(k)}, 1'h0);
            wr_reg(8'h03, {3'(k), 3'(7 - k), 1'h1, k[0]}, 1'h1);
            wr_reg(8'h01, {3'(7 - k), k[1], k[0], 3'(k)}, 1'h0);
            rd_exp(8'h02);
            rd_exp(8'h03);
        end
        // Random contents, with unmapped writes that must change nothing
        repeat (30) begin
            ra = 8'(1 + ({$random(seed)} % 3));
            wr_reg(ra, 8'($random(seed)), 1'h0);
            rd_exp(ra);
            wr_reg(8'($random(seed)) | 8'h04, 8'($random(seed)), 1'h0);
        end
        // Write and read-back in consecutive cycles
        repeat (4) begin
            ra = 8'($random(seed));
            shadow[1] = ra;
            host.wr_rd(8'h01, ra, {1'h1, ra});
            #1;
            check(ctrl, decode());
        end
        for (int a = 1; a < 4; a++) rd_exp(8'(a));
        // Ready flag set, cleared, both at once, and not writable
        pulse(1'h1, 1'h0);
        rd_exp(8'h02);
        pulse(1'h0, 1'h1);
        rd_exp(8'h02);
        pulse(1'h1, 1'h1);
        wr_reg(8'h02, 8'h00, 1'h0);
        rd_exp(8'h02);
        pulse(1'h0, 1'h1);
        wr_reg(8'h02, 8'h80, 1'h0);
        rd_exp(8'h02);
        for (int i = 0; i < 10 && host.exp_q.size() != 0; i++) @(posedge clk);
        check(64'(host.exp_q.size()), 64'h0);
        conclude();
    end
endmodule : testbench
